// ===== src/memdec_pkg.sv
// Shared constants for the main-memory decode and host window block
package memdec_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TOP = 8'h04;
  localparam logic [7:0] OFS_HOLE = 8'h08;
  localparam logic [7:0] OFS_BIOS = 8'h0C;
  localparam logic [7:0] OFS_FWD0 = 8'h10;
  localparam logic [7:0] OFS_FWD1 = 8'h14;
  localparam logic [7:0] OFS_WBASE = 8'h18;
  localparam logic [7:0] OFS_WMASK = 8'h1C;
  localparam logic [7:0] OFS_SYSCTL = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_DEC_EN = 0;
  localparam int CTL_LOW_EN = 1;
  localparam int CTL_MID_EN = 2;
  localparam int CTL_HOLE_EN = 3;
  localparam int CTL_FWD0_EN = 4;
  localparam int CTL_FWD1_EN = 5;
  localparam int WB_WIN_EN = 0;
  localparam int WB_SG = 1;
  localparam int WB_SEL_PATH = 2;
  localparam int TOP_W = 9;
  localparam int SEG_W = 16;
  localparam int MB_LSB = 20;
  // ----------------------------------------------------------------
  // Reset values and fixed address regions
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [7:0] RST_SYSCTL = 8'h00;
  localparam logic [31:0] LOW_END = 32'h0008_0000;
  localparam logic [31:0] MID_END = 32'h000A_0000;
  localparam logic [31:0] GFX_END = 32'h000C_0000;
  localparam logic [31:0] BIOS_END = 32'h0010_0000;
  localparam logic [31:0] ONE_MB = 32'h0010_0000;
  localparam logic [2:0] MEM_TOP_BITS = 3'h0;
  // ----------------------------------------------------------------
  // Subtractive claim timing: positive targets answer by slow DEVSEL
  // ----------------------------------------------------------------
  localparam int SUB_WAIT_NS = 16;
  localparam int CLK_NS = 4;
  localparam int SUB_WAIT_CYC = (SUB_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SUB_CNT_INIT = 4'(SUB_WAIT_CYC);
  typedef enum logic [1:0] {SUB_IDLE, SUB_WAIT, SUB_CLAIM} sub_state_type;
endpackage : memdec_pkg

// ===== src/mem_select_decode.sv
// Combinational main-memory select decode for one address
`timescale 1ns/1ps
`default_nettype none
module mem_select_decode
  import memdec_pkg::*;
(
  input wire logic [31:0] i_addr, // Address under decode
  input wire logic [31:0] i_ctrl, // Memory decode control
  input wire logic [TOP_W-1:0] i_top, // Top of memory, 2 MB units
  input wire logic [31:0] i_hole, // Hole top/bottom, 64 KB units
  input wire logic [15:0] i_bios, // BIOS segment enables
  output logic o_select // High when main memory is addressed
);
  logic below_top;
  logic region_ok;
  logic in_hole;
  // ----------------------------------------------------------------
  // Top of memory: zero means the first megabyte only
  // ----------------------------------------------------------------
  always_comb begin
    if (i_top == '0) begin
      below_top = (i_addr < ONE_MB);
    end else begin
      below_top = ({2'h0, i_addr[31:21]} < {4'h0, i_top});
    end
  end
  // ----------------------------------------------------------------
  // Fixed regions below 1 MB
  // ----------------------------------------------------------------
  always_comb begin
    if (i_addr < LOW_END) begin
      region_ok = i_ctrl[CTL_LOW_EN];
    end else if (i_addr < MID_END) begin
      region_ok = i_ctrl[CTL_MID_EN];
    end else if (i_addr < GFX_END) begin
      // RULE_08 graphics hole fixed
      region_ok = 1'b0;
    end else if (i_addr < BIOS_END) begin
      // RULE_06 BIOS segment enables
      region_ok = i_bios[i_addr[17:14]];
    end else begin
      region_ok = 1'b1;
    end
  end
  // RULE_05 programmable hole, 64 KB
  assign in_hole = i_ctrl[CTL_HOLE_EN] && (i_addr[31:16] >= i_hole[15:0])
                   && (i_addr[31:16] <= i_hole[31:16]);
  // RULE_09 select outside holes
  // RULE_23 dead while decoder off
  assign o_select = i_ctrl[CTL_DEC_EN] && (i_addr[31:29] == MEM_TOP_BITS)
                    && below_top && region_ok && !in_hole;
endmodule : mem_select_decode
`default_nettype wire

// ===== src/forward_region_match.sv
// Base/limit match of an expansion address against forwarding regions
`timescale 1ns/1ps
`default_nettype none
module forward_region_match #(
  parameter int NUM = 2 // Number of forwarding regions
) (
  input wire logic [15:0] i_seg, // Address bits 31:16
  input wire logic [NUM*32-1:0] i_regions, // Limit high, base low per region
  input wire logic [NUM-1:0] i_enable, // Region enables
  output logic o_match // Address falls in an enabled region
);
  logic [NUM-1:0] hit;
  // RULE_10 base/limit in 64 KB
  for (genvar g = 0; g < NUM; g++) begin : g_reg
    assign hit[g] = i_enable[g] && (i_seg >= i_regions[g*32 +: 16])
                    && (i_seg <= i_regions[g*32+16 +: 16]);
  end
  assign o_match = |hit;
endmodule : forward_region_match
`default_nettype wire

// ===== src/memory_hole_decode.sv
// Main-memory decode, hole logic and host window 0 qualification
//
// Summary of operation
// RULE_01 - PCI cycles claimed subtractively only.
// RULE_02 - No main memory in device holes.
// RULE_03 - Positive decode below 512 MB.
// RULE_04 - Top of memory, 2 MB steps, 1-512 MB.
// RULE_05 - One 64 KB hole never selects.
// RULE_06 - BIOS segments follow their enables.
// RULE_07 - Control enables decoder, low regions.
// RULE_08 - A0000-BFFFF never selects.
// RULE_09 - Select outside disabled regions, holes.
// RULE_10 - Forwarding via 64 KB base/limit.
// RULE_11 - Software keeps forwarding, memory disjoint.
// RULE_12 - Forwarded cycles never select.
// RULE_13 - Hole blocks only expansion-to-memory; code blocks PCI-to-memory in the hole too.
// RULE_14 - Path on: window 0 hit equals select.
// RULE_15 - Path on: no select, no hit.
// RULE_16 - Path enable overrides window enable.
// RULE_17 - Scatter/gather bit still applies.
// RULE_18 - Software sizes base and mask to region.
// RULE_19 - Slow DEVSEL whenever path enabled.
// RULE_20 - Software sets bridge slow DEVSEL mode.
// RULE_21 - Window base, mask in 1 MB units.
// RULE_22 - Software zeroes system-control 0, 1, 4, 7:6.
// RULE_23 - No select until decoder enabled.
`timescale 1ns/1ps
`default_nettype none
module memory_hole_decode
  import memdec_pkg::*;
#(
  parameter int NUM_FWD = 2 // Number of forwarding regions
) (
  input wire logic i_clk, // Clock
  input wire logic i_reset, // Async reset
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB write
  input wire logic [7:0] i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  output logic [31:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // Unmapped offset
  input wire logic i_pci_valid, // PCI address valid
  input wire logic i_pci_start, // PCI cycle start
  input wire logic [31:0] i_pci_addr, // PCI address
  input wire logic i_pci_claimed, // Positive target claimed
  input wire logic i_eisa_valid, // Expansion cycle valid
  input wire logic [31:0] i_eisa_addr, // Expansion address
  output logic o_main_memory_select_n, // Memory select
  output logic o_eisa_forward, // Forwarded to PCI
  output logic o_subtractive_claim, // Subtractive claim
  output logic o_window0_hit, // Window 0 hit
  output logic o_window0_sg, // Window 0 scatter/gather
  output logic o_devsel_slow, // Slow DEVSEL timing
  output logic [7:0] o_system_control // System-control port
);
  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [31:0] memory_decode_control_r;
  logic [TOP_W-1:0] memory_top_limit_r;
  logic [31:0] hole_limits_r;
  logic [15:0] bios_region_enables_r;
  logic [NUM_FWD*32-1:0] pci_forward_regions_r;
  logic [31:0] window0_base_r;
  logic [31:0] window0_mask_r;
  logic [7:0] system_control_port_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic wr_en;
  logic rd_setup;
  logic pci_sel;
  logic eisa_sel;
  logic eisa_fwd;
  logic win_hit_nxt;
  logic select_n_r;
  logic forward_r;
  logic hit_r;
  logic sg_r;
  logic claim_r;
  logic [3:0] sub_cnt_r;
  sub_state_type sub_state_r;
  logic [NUM_FWD-1:0] fwd_en;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // Valid offset check, shared by read and write paths
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_CTRL) || (a == OFS_TOP) || (a == OFS_HOLE)
                || (a == OFS_BIOS) || (a == OFS_FWD0) || (a == OFS_FWD1)
                || (a == OFS_WBASE) || (a == OFS_WMASK)
                || (a == OFS_SYSCTL) || (a == OFS_STATUS);
  endfunction : is_mapped

  // Writes land on the access phase; reads are latched in setup
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_setup = i_psel && !i_penable;
  assign o_pready = 1'b1;
  assign o_prdata = prdata_r;
  assign o_pslverr = pslverr_r && i_psel && i_penable;

  // RULE_07 control register write
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      memory_decode_control_r <= RST_ZERO;
    end else if (wr_en && i_paddr == OFS_CTRL) begin
      memory_decode_control_r <= i_pwdata;
    end
  end

  // RULE_04 top of memory, 2 MB steps
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      memory_top_limit_r <= '0;
    end else if (wr_en && i_paddr == OFS_TOP) begin
      memory_top_limit_r <= i_pwdata[TOP_W-1:0];
    end
  end

  // RULE_05 hole bottom low, top high
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      hole_limits_r <= RST_ZERO;
    end else if (wr_en && i_paddr == OFS_HOLE) begin
      hole_limits_r <= i_pwdata;
    end
  end

  // RULE_06 BIOS segment enables
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      bios_region_enables_r <= '0;
    end else if (wr_en && i_paddr == OFS_BIOS) begin
      bios_region_enables_r <= i_pwdata[15:0];
    end
  end

  // RULE_10 forwarding region limits
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pci_forward_regions_r <= '0;
    end else if (wr_en && i_paddr == OFS_FWD0) begin
      pci_forward_regions_r[31:0] <= i_pwdata;
    end else if (wr_en && i_paddr == OFS_FWD1) begin
      pci_forward_regions_r[63:32] <= i_pwdata;
    end
  end

  // RULE_21 window base and mask, 1 MB resolution
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      window0_base_r <= RST_ZERO;
      window0_mask_r <= RST_ZERO;
    end else if (wr_en && i_paddr == OFS_WBASE) begin
      window0_base_r <= {i_pwdata[31:MB_LSB], 17'h0, i_pwdata[2:0]};
    end else if (wr_en && i_paddr == OFS_WMASK) begin
      window0_mask_r <= {i_pwdata[31:MB_LSB], 20'h0};
    end
  end

  // System-control port: stored as written, software keeps fixed bits low
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      system_control_port_r <= RST_SYSCTL;
    end else if (wr_en && i_paddr == OFS_SYSCTL) begin
      system_control_port_r <= i_pwdata[7:0];
    end
  end
  assign o_system_control = system_control_port_r;

  // Read data and error latched in setup so outputs come from flops
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      prdata_r <= RST_ZERO;
      pslverr_r <= 1'b0;
    end else if (rd_setup) begin
      pslverr_r <= !is_mapped(i_paddr);
      unique case (i_paddr)
        OFS_CTRL: prdata_r <= memory_decode_control_r;
        OFS_TOP: prdata_r <= {23'h0, memory_top_limit_r};
        OFS_HOLE: prdata_r <= hole_limits_r;
        OFS_BIOS: prdata_r <= {16'h0, bios_region_enables_r};
        OFS_FWD0: prdata_r <= pci_forward_regions_r[31:0];
        OFS_FWD1: prdata_r <= pci_forward_regions_r[63:32];
        OFS_WBASE: prdata_r <= window0_base_r;
        OFS_WMASK: prdata_r <= window0_mask_r;
        OFS_SYSCTL: prdata_r <= {24'h0, system_control_port_r};
        OFS_STATUS: prdata_r <= {26'h0, sub_state_r, claim_r, hit_r,
                                 forward_r, !select_n_r};
        default: prdata_r <= RST_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address decoders
  // ----------------------------------------------------------------
  // RULE_03 positive decode, PCI side
  mem_select_decode u_pci_dec (
    .i_addr(i_pci_addr),
    .i_ctrl(memory_decode_control_r),
    .i_top(memory_top_limit_r),
    .i_hole(hole_limits_r),
    .i_bios(bios_region_enables_r),
    .o_select(pci_sel)
  );

  // RULE_03 positive decode, expansion side
  mem_select_decode u_eisa_dec (
    .i_addr(i_eisa_addr),
    .i_ctrl(memory_decode_control_r),
    .i_top(memory_top_limit_r),
    .i_hole(hole_limits_r),
    .i_bios(bios_region_enables_r),
    .o_select(eisa_sel)
  );

  assign fwd_en = memory_decode_control_r[CTL_FWD1_EN:CTL_FWD0_EN];

  forward_region_match #(
    .NUM(NUM_FWD)
  ) u_fwd (
    .i_seg(i_eisa_addr[31:16]),
    .i_regions(pci_forward_regions_r),
    .i_enable(fwd_en),
    .o_match(eisa_fwd)
  );

  // ----------------------------------------------------------------
  // Main-memory select output
  // ----------------------------------------------------------------
  // RULE_12 forwarded cycles not selected
  // RULE_02 holes leave select high
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      select_n_r <= 1'b1;
      forward_r <= 1'b0;
    end else begin
      select_n_r <= !((i_pci_valid && pci_sel)
                      || (i_eisa_valid && eisa_sel && !eisa_fwd));
      forward_r <= i_eisa_valid && eisa_fwd;
    end
  end
  assign o_main_memory_select_n = select_n_r;
  assign o_eisa_forward = forward_r;

  // ----------------------------------------------------------------
  // Host window 0 qualification
  // ----------------------------------------------------------------
  // RULE_16 select path overrides enable
  // RULE_14 hit equals select
  // RULE_15 no select, no hit
  always_comb begin
    if (window0_base_r[WB_SEL_PATH]) begin
      win_hit_nxt = i_pci_valid && pci_sel;
    end else begin
      win_hit_nxt = i_pci_valid && window0_base_r[WB_WIN_EN]
                    && ((i_pci_addr[31:MB_LSB] & ~window0_mask_r[31:MB_LSB])
                        == (window0_base_r[31:MB_LSB]
                            & ~window0_mask_r[31:MB_LSB]));
    end
  end

  // RULE_17 scatter/gather still applies
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      hit_r <= 1'b0;
      sg_r <= 1'b0;
    end else begin
      hit_r <= win_hit_nxt;
      sg_r <= win_hit_nxt && window0_base_r[WB_SG];
    end
  end
  assign o_window0_hit = hit_r;
  assign o_window0_sg = sg_r;
  // RULE_19 slow DEVSEL with select path
  assign o_devsel_slow = window0_base_r[WB_SEL_PATH];

  // ----------------------------------------------------------------
  // Subtractive claim of PCI cycles
  // ----------------------------------------------------------------
  // RULE_01 claim only when unclaimed
  // RULE_13 hole addresses reach expansion bus
  // Waits out the slow DEVSEL slot so no positive target is pre-empted
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sub_state_r <= SUB_IDLE;
      sub_cnt_r <= '0;
      claim_r <= 1'b0;
    end else begin
      claim_r <= 1'b0;
      unique case (sub_state_r)
        SUB_IDLE: begin
          if (i_pci_start) begin
            sub_state_r <= SUB_WAIT;
            sub_cnt_r <= SUB_CNT_INIT;
          end
        end
        SUB_WAIT: begin
          if (i_pci_claimed || hit_r) begin
            sub_state_r <= SUB_IDLE;
          end else if (sub_cnt_r == 4'h1) begin
            sub_state_r <= SUB_CLAIM;
          end else begin
            sub_cnt_r <= sub_cnt_r - 4'h1;
          end
        end
        SUB_CLAIM: begin
          claim_r <= 1'b1;
          sub_state_r <= SUB_IDLE;
        end
      endcase
    end
  end
  assign o_subtractive_claim = claim_r;
endmodule : memory_hole_decode
`default_nettype wire

// ===== verification/memory_hole_decode_assertions.sv
// Port-level checks for the main-memory decode block
`timescale 1ns/1ps
`default_nettype none
module memory_hole_decode_assertions
  import memdec_pkg::*;
(
  input wire logic i_clk, // Clock
  input wire logic i_reset, // Reset
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB write
  input wire logic [7:0] i_paddr, // APB address
  input wire logic [31:0] i_pwdata, // APB data
  input wire logic o_pslverr, // APB error
  input wire logic i_pci_valid, // PCI valid
  input wire logic i_pci_start, // PCI start
  input wire logic [31:0] i_pci_addr, // PCI address
  input wire logic i_eisa_valid, // Expansion valid
  input wire logic [31:0] i_eisa_addr, // Expansion address
  input wire logic o_main_memory_select_n, // Select, low active
  input wire logic o_eisa_forward, // Forwarded
  input wire logic o_subtractive_claim, // Claim
  input wire logic o_window0_hit, // Window hit
  input wire logic o_window0_sg, // Window SG
  input wire logic o_devsel_slow // Slow DEVSEL
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic dec_en_r; // Shadow of decoder enable
  logic wr_cyc; // APB write completes this edge
  logic any_valid; // Some master presents an address
  logic one_src; // One master only
  logic [31:0] dec_addr; // Address under decode
  assign wr_cyc = i_psel && i_penable && i_pwrite;
  assign any_valid = i_pci_valid | i_eisa_valid;
  assign one_src = i_pci_valid ^ i_eisa_valid;
  assign dec_addr = i_pci_valid ? i_pci_addr : i_eisa_addr;
  // Zero-wait slave
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      dec_en_r <= 1'b0;
    end else if (wr_cyc && i_paddr == OFS_CTRL) begin
      dec_en_r <= i_pwdata[CTL_DEC_EN];
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_sel_has_src: assert property (
    !o_main_memory_select_n |-> $past(any_valid)) else $error("select without a master");
  a_gfx_never: assert property (
    one_src && dec_addr >= MID_END && dec_addr < GFX_END |=> o_main_memory_select_n)
    else $error("select in graphics hole");
  a_off_quiet: assert property (
    !dec_en_r && !$past(dec_en_r) |-> o_main_memory_select_n)
    else $error("select while decoder off");
  a_path_hit_eq: assert property (
    o_devsel_slow && $past(o_devsel_slow) && !$past(i_eisa_valid)
    |-> o_window0_hit == !o_main_memory_select_n) else $error("window hit not select");
  a_slow_cause: assert property (
    $rose(o_devsel_slow) |-> $past(wr_cyc && i_paddr == OFS_WBASE && i_pwdata[WB_SEL_PATH]))
    else $error("slow timing without path write");
  a_sg_in_hit: assert property (
    o_window0_sg |-> o_window0_hit) else $error("scatter gather without hit");
  a_fwd_no_sel: assert property (
    o_eisa_forward && !$past(i_pci_valid) |-> o_main_memory_select_n)
    else $error("select on forwarded cycle");
  a_claim_delay: assert property (
    $rose(o_subtractive_claim) |-> $past(i_pci_start, 6)) else $error("claim at wrong edge");
  a_claim_pulse: assert property (
    o_subtractive_claim |=> !o_subtractive_claim) else $error("claim longer than a cycle");
  a_err_access: assert property (
    o_pslverr |-> i_psel && i_penable) else $error("error outside access phase");
endmodule : memory_hole_decode_assertions
bind memory_hole_decode memory_hole_decode_assertions u_chk (.*);
`default_nettype wire

// ===== verification/pci_peer_target.sv
// Behavioural positive PCI target that may claim a cycle
`timescale 1ns/1ps
`default_nettype none
module pci_peer_target (
  input wire logic i_clk, // Clock
  input wire logic i_reset, // Reset
  input wire logic i_start, // Cycle start pulse
  input wire logic i_respond, // Target owns the address
  input wire logic i_slow, // Slow DEVSEL programmed
  output logic o_claimed // DEVSEL of this target
);
  logic busy_r; // Decode in progress
  logic [3:0] wait_r; // Cycles left before claiming
  logic [2:0] hold_r; // Cycles left holding DEVSEL
  // slow mode answer
  // Claim must land inside the bridge wait or the bridge also claims
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      busy_r <= 1'b0;
      wait_r <= 4'h0;
      hold_r <= 3'h0;
    end else if (i_start && i_respond) begin
      busy_r <= 1'b1;
      wait_r <= i_slow ? 4'h3 : 4'h1;
    end else if (busy_r && wait_r == 4'h1) begin
      busy_r <= 1'b0;
      hold_r <= 3'h4;
    end else begin
      wait_r <= wait_r - {3'h0, busy_r};
      hold_r <= hold_r - {2'h0, |hold_r};
    end
  end
  assign o_claimed = |hold_r;
endmodule : pci_peer_target
`default_nettype wire

// ===== verification/memory_hole_decode_tb.sv
// Self-checking bench for the main-memory decode block
`timescale 1ns/1ps
`default_nettype none
module memory_hole_decode_tb;
  import memdec_pkg::*;
  logic i_clk = 1'b0, i_reset = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, i_pci_addr = 32'h0, i_eisa_addr = 32'h0, o_prdata;
  logic i_pci_valid = 1'b0, i_pci_start = 1'b0, i_eisa_valid = 1'b0, i_pci_claimed;
  logic peer_respond = 1'b0, peer_slow = 1'b0, o_pready, o_pslverr, o_main_memory_select_n;
  logic o_eisa_forward, o_subtractive_claim, o_window0_hit, o_window0_sg, o_devsel_slow;
  logic [7:0] o_system_control;
  int fails = 0, num_checks = 0;
  memory_hole_decode u_dut (.*);
  pci_peer_target u_peer (.i_clk, .i_reset, .i_start(i_pci_start),
    .i_respond(peer_respond), .i_slow(peer_slow), .o_claimed(i_pci_claimed));
  // 250 MHz clock
  always #2 i_clk = ~i_clk;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One APB transfer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (n >= 16) fails++;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("read data", r, exp);
    chk("slave error", {31'h0, e}, {31'h0, exp_err});
  endtask : rd_chk
  // One-cycle address probe
  task automatic probe(input logic pci, input logic [31:0] a);
    @(posedge i_clk);
    i_pci_valid <= pci;
    i_eisa_valid <= !pci;
    i_pci_addr <= a;
    i_eisa_addr <= a;
    @(posedge i_clk);
    i_pci_valid <= 1'b0;
    i_eisa_valid <= 1'b0;
    #1;
  endtask : probe
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] offs[10] = '{OFS_CTRL, OFS_TOP, OFS_HOLE, OFS_BIOS, OFS_FWD0, OFS_FWD1,
                             OFS_WBASE, OFS_WMASK, OFS_SYSCTL, OFS_STATUS};
    foreach (offs[i]) rd_chk(offs[i], RST_ZERO, 1'b0);
    wr(OFS_HOLE, 32'hA5C3_5A3C);
    rd_chk(OFS_HOLE, 32'hA5C3_5A3C, 1'b0);
    wr(OFS_TOP, 32'h0000_0FFF);
    rd_chk(OFS_TOP, 32'h0000_01FF, 1'b0);
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rd_chk(OFS_STATUS, RST_ZERO, 1'b0);
    // only free bit 3 is set
    wr(OFS_SYSCTL, 32'h0000_0008);
    rd_chk(OFS_SYSCTL, 32'h0000_0008, 1'b0);
    chk("system control", {24'h0, o_system_control}, 32'h0000_0008);
    wr(8'h28, 32'hFFFF_FFFF);
    rd_chk(8'h28, RST_ZERO, 1'b1);
    $display("test registers done");
  endtask : t_regs
  task automatic t_decode();
    logic [31:0] da[16] = '{32'h0, 32'h7FFFF, 32'h80000, 32'h9FFFF, 32'hA0000, 32'hBFFFF,
      32'hC0000, 32'hC3FFF, 32'hC4000, 32'h100000, 32'h2FFFFF, 32'h300000, 32'h31FFFF,
      32'h320000, 32'h3FFFFF, 32'h400000};
    logic [15:0] de = 16'hF366;
    probe(1'b0, 32'h0020_0000);
    chk("select off", o_main_memory_select_n, 32'h1);
    wr(OFS_TOP, 32'h0000_0002);
    wr(OFS_HOLE, 32'h0031_0030);
    wr(OFS_BIOS, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_000F);
    for (int m = 0; m < 2; m++) begin
      foreach (da[i]) begin
        probe(m[0], da[i]);
        chk("select", o_main_memory_select_n, !de[15-i]);
      end
    end
    wr(OFS_BIOS, 32'h0000_FFFF);
    wr(OFS_CTRL, 32'h0000_000D);
    probe(1'b0, 32'h0);
    chk("low region off", o_main_memory_select_n, 32'h1);
    probe(1'b0, 32'hFFFFF);
    chk("bios region on", o_main_memory_select_n, 32'h0);
    $display("test decode done");
  endtask : t_decode
  task automatic t_forward();
    logic [31:0] fa[6] = '{32'h500000, 32'h51FFFF, 32'h520000, 32'h4F0000, 32'h300000,
                           32'h200000};
    logic [5:0] fe = 6'h32;
    // forwarding only above memory or in the hole
    wr(OFS_FWD0, 32'h0051_0050);
    wr(OFS_FWD1, 32'h0030_0030);
    wr(OFS_CTRL, 32'h0000_003F);
    foreach (fa[i]) begin
      probe(1'b0, fa[i]);
      chk("forward", o_eisa_forward, fe[5-i]);
      chk("select", o_main_memory_select_n, i != 5);
    end
    $display("test forward done");
  endtask : t_forward
  task automatic win(input logic [31:0] a, input logic h, input logic sg, input logic sl);
    probe(1'b1, a);
    chk("window hit", o_window0_hit, h);
    chk("window sg", o_window0_sg, sg);
    chk("slow devsel", o_devsel_slow, sl);
  endtask : win
  task automatic t_window();
    wr(OFS_WMASK, 32'h0);
    wr(OFS_WBASE, 32'h0020_0001);
    win(32'h1FFFFF, 1'b0, 1'b0, 1'b0);
    win(32'h200000, 1'b1, 1'b0, 1'b0);
    win(32'h2FFFFF, 1'b1, 1'b0, 1'b0);
    win(32'h300000, 1'b0, 1'b0, 1'b0);
    wr(OFS_WBASE, 32'h0000_0006);
    win(32'h200000, 1'b1, 1'b1, 1'b1);
    win(32'hA0000, 1'b0, 1'b0, 1'b1);
    win(32'h300000, 1'b0, 1'b0, 1'b1);
    $display("test window done");
  endtask : t_window
  task automatic claim_run(input logic [31:0] a, input logic resp, input logic slow,
                           input int exp_k);
    int got;
    got = 0;
    @(posedge i_clk);
    i_pci_valid <= 1'b1;
    i_pci_addr <= a;
    peer_respond <= resp;
    peer_slow <= slow;
    i_pci_start <= 1'b1;
    @(posedge i_clk);
    i_pci_start <= 1'b0;
    for (int k = 1; k <= 12; k++) begin
      #1;
      if (o_subtractive_claim === 1'b1 && got == 0) got = k;
      @(posedge i_clk);
    end
    i_pci_valid <= 1'b0;
    chk("claim edge", got, exp_k);
  endtask : claim_run
  task automatic t_claim();
    claim_run(32'h300000, 1'b0, 1'b0, SUB_WAIT_CYC + 2);
    claim_run(32'h200000, 1'b0, 1'b0, 0);
    claim_run(32'h600000, 1'b0, 1'b0, SUB_WAIT_CYC + 2);
    claim_run(32'h600000, 1'b1, 1'b0, 0);
    claim_run(32'h600000, 1'b1, 1'b1, 0);
    $display("test claim done");
  endtask : t_claim
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    t_regs();
    t_decode();
    t_forward();
    t_window();
    t_claim();
    report_and_stop();
  end
  // Watchdog, 10000 cycles
  initial begin
    #40000;
    fails++;
    report_and_stop();
  end
endmodule : memory_hole_decode_tb
`default_nettype wire
